/* shared/ssp_pkg.sv */
// Constants and types shared by the sensor serial port
package ssp_pkg;
  // ****************************************
  // Geometry of the register space
  // ****************************************
  localparam int SSP_ADDR_W = 6;
  localparam int SSP_DATA_W = 8;
  localparam int SSP_CNT_W = 3;
  // ****************************************
  // First byte layout
  // ****************************************
  localparam int SSP_RW_POS = 7;
  localparam int SSP_MB_POS = 6;
  // ****************************************
  // Data format register and its wire-count bit
  // ****************************************
  localparam logic [5:0] SSP_FMT_ADDR = 6'h31;
  localparam int SSP_WIRE_POS = 6;
  localparam logic SSP_WIRE_RST = 1'b0;
  localparam logic [7:0] SSP_RDATA_RST = 8'h00;
  // ****************************************
  // Link timing, serial clock ceiling
  // ****************************************
  localparam int SSP_SCLK_MAX_KHZ = 5000;
  localparam int SSP_MCLK_KHZ = 10000;
  // ****************************************
  // Transaction phases
  // ****************************************
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_HDR = 2'b01,
    SSP_DATA = 2'b10
  } ssp_phase_e;
endpackage

/* rtl/ssp_regfile.sv */
// Register memory behind the serial port, registered read
`timescale 1ns/1ps
module ssp_regfile
  import ssp_pkg::*;
#(
  parameter int AW = SSP_ADDR_W,
  parameter int DW = SSP_DATA_W
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_ff
);
  logic [DW-1:0] mem [2**AW];

  // ****************************************
  // Storage
  // ****************************************
  // Write port, no reset on the array
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data out of a register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rd_data_ff <= DW'(SSP_RDATA_RST);
    else
      rd_data_ff <= mem[rd_addr];
  end
endmodule

/* rtl/ssp_spi_slave.sv */
// SPI slave front end of the sensor serial port
`timescale 1ns/1ps
module ssp_spi_slave
  import ssp_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic twowire_sel,
  output logic three_wire,
  output logic reg_wr_stb,
  output logic [SSP_ADDR_W-1:0] reg_wr_addr,
  output logic [SSP_DATA_W-1:0] reg_wr_data
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] cs_sync_ff;
  logic [2:0] sclk_sync_ff;
  logic [1:0] sdi_sync_ff;
  logic [1:0] sdio_sync_ff;

  // Two stages per pin, clock gets a third for edges
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cs_sync_ff <= 2'h3;
      sclk_sync_ff <= 3'h7;
      sdi_sync_ff <= 2'h3;
      sdio_sync_ff <= 2'h3;
    end
    else
    begin
      cs_sync_ff <= {cs_sync_ff[0], cs_n};
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
      sdi_sync_ff <= {sdi_sync_ff[0], sdi};
      sdio_sync_ff <= {sdio_sync_ff[0], sdio_in};
    end
  end

  // ****************************************
  // Edge and frame decode
  // ****************************************
  logic cs_hi;
  logic sclk_rise;
  logic sclk_fall;
  logic din;
  // Clock idles high, so a frame opens on a fall
  assign cs_hi = cs_sync_ff[1];
  assign sclk_rise = !cs_hi && sclk_sync_ff[1] && !sclk_sync_ff[2];
  assign sclk_fall = !cs_hi && !sclk_sync_ff[1] && sclk_sync_ff[2];

  // ****************************************
  // Frame state
  // ****************************************
  ssp_phase_e phase_ff;
  ssp_phase_e nxt_phase;
  logic [SSP_CNT_W-1:0] bit_cnt_ff;
  logic [SSP_DATA_W-2:0] shift_in_ff;
  logic [SSP_DATA_W-1:0] shift_out_ff;
  logic rw_ff;
  logic mb_ff;
  logic [SSP_ADDR_W-1:0] ptr_ff;
  logic three_wire_ff;
  logic sdo_ff;
  logic sdo_oe_ff;
  logic sdio_oe_ff;
  logic twowire_sel_ff;
  logic reg_wr_stb_ff;
  logic [SSP_ADDR_W-1:0] reg_wr_addr_ff;
  logic [SSP_DATA_W-1:0] reg_wr_data_ff;
  logic [SSP_DATA_W-1:0] rd_data;

  logic byte_done;
  logic [SSP_DATA_W-1:0] byte_in;
  logic in_data;
  logic wr_en;
  logic fmt_hit;
  logic load_out;
  logic [SSP_DATA_W-1:0] out_word;
  logic read_drive;
  // Input pin follows the wire-count mode
  assign din = three_wire_ff ? sdio_sync_ff[1] : sdi_sync_ff[1];
  assign byte_done = sclk_rise && (bit_cnt_ff == SSP_CNT_W'(SSP_DATA_W - 1));
  assign byte_in = {shift_in_ff, din};
  assign in_data = (phase_ff == SSP_DATA);
  assign wr_en = byte_done && in_data && !rw_ff;
  assign fmt_hit = (ptr_ff == SSP_FMT_ADDR);
  // Fresh word at the first fall of each data byte
  assign load_out = sclk_fall && in_data && (bit_cnt_ff == '0);
  assign out_word = load_out ? rd_data : shift_out_ff;
  assign read_drive = !cs_hi && in_data && rw_ff;

  // Phase sequencing, select high ends everything
  always_comb
  begin
    nxt_phase = phase_ff;
    case (phase_ff)
      SSP_IDLE: if (!cs_hi) nxt_phase = SSP_HDR;
      SSP_HDR: if (cs_hi) nxt_phase = SSP_IDLE; else if (byte_done) nxt_phase = SSP_DATA;
      SSP_DATA: if (cs_hi) nxt_phase = SSP_IDLE;
      default: nxt_phase = SSP_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      phase_ff <= SSP_IDLE;
    else
      phase_ff <= nxt_phase;
  end

  // Capture on rising clock, bit count per byte
  always_ff @(posedge mclk)
  begin
    if (sys_rst || cs_hi)
    begin
      bit_cnt_ff <= '0;
      shift_in_ff <= '0;
    end
    else if (sclk_rise)
    begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
      shift_in_ff <= byte_in[SSP_DATA_W-2:0];
    end
  end

  // Header fields and register pointer
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rw_ff <= 1'b0;
      mb_ff <= 1'b0;
      ptr_ff <= '0;
    end
    else if (byte_done && (phase_ff == SSP_HDR))
    begin
      rw_ff <= byte_in[SSP_RW_POS];
      mb_ff <= byte_in[SSP_MB_POS];
      ptr_ff <= byte_in[SSP_ADDR_W-1:0];
    end
    else if (byte_done && in_data && mb_ff)
    begin
      ptr_ff <= ptr_ff + 1'b1;
    end
  end

  // Wire-count shadow of the data format register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      three_wire_ff <= SSP_WIRE_RST;
    else if (wr_en && fmt_hit)
      three_wire_ff <= byte_in[SSP_WIRE_POS];
  end

  // Shift out on falling clock
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      shift_out_ff <= '0;
      sdo_ff <= 1'b1;
    end
    else if (sclk_fall && in_data)
    begin
      sdo_ff <= out_word[SSP_DATA_W-1];
      shift_out_ff <= {out_word[SSP_DATA_W-2:0], 1'b0};
    end
  end

  // Drivers: never while deselected, shared pin only on reads
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sdo_oe_ff <= 1'b0;
      sdio_oe_ff <= 1'b0;
      twowire_sel_ff <= 1'b1;
    end
    else
    begin
      sdo_oe_ff <= !cs_hi && !three_wire_ff;
      sdio_oe_ff <= read_drive && three_wire_ff;
      twowire_sel_ff <= cs_hi;
    end
  end

  // Write strobe toward the sensor core
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      reg_wr_stb_ff <= 1'b0;
      reg_wr_addr_ff <= '0;
      reg_wr_data_ff <= '0;
    end
    else
    begin
      reg_wr_stb_ff <= wr_en;
      reg_wr_addr_ff <= ptr_ff;
      reg_wr_data_ff <= byte_in;
    end
  end

  // ****************************************
  // Register memory
  // ****************************************
  ssp_regfile #(
    .AW(SSP_ADDR_W),
    .DW(SSP_DATA_W)
  ) u_regs (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(wr_en),
    .wr_addr(ptr_ff),
    .wr_data(byte_in),
    .rd_addr(ptr_ff),
    .rd_data_ff(rd_data)
  );

  // Output pins
  assign sdo = sdo_ff;
  assign sdio_out = sdo_ff;
  assign sdo_oe = sdo_oe_ff;
  assign sdio_oe = sdio_oe_ff;
  assign twowire_sel = twowire_sel_ff;
  assign three_wire = three_wire_ff;
  assign reg_wr_stb = reg_wr_stb_ff;
  assign reg_wr_addr = reg_wr_addr_ff;
  assign reg_wr_data = reg_wr_data_ff;

  // ****************************************
  // Checks
  // ****************************************
  a_no_drive_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    twowire_sel_ff |-> !sdo_oe_ff && !sdio_oe_ff)
    else $error("driver on while deselected");
  a_select_release: assert property (@(posedge mclk) disable iff (sys_rst)
    cs_hi |=> !sdo_oe_ff && !sdio_oe_ff && twowire_sel_ff)
    else $error("output not released after select rose");
  a_twowire_hand: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(cs_hi) |=> !twowire_sel_ff)
    else $error("two-wire select stuck during frame");
  a_shared_pin_use: assert property (@(posedge mclk) disable iff (sys_rst)
    sdio_oe_ff |-> three_wire_ff && rw_ff && $past(in_data))
    else $error("shared pin driven outside read data");
  a_four_wire_pin: assert property (@(posedge mclk) disable iff (sys_rst)
    sdo_oe_ff |-> $past(!three_wire_ff))
    else $error("output pin driven in 3-wire mode");
  a_out_on_fall: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 $changed(sdo_ff) |-> $past(sclk_fall))
    else $error("output changed away from falling clock");
  a_ptr_advance: assert property (@(posedge mclk) disable iff (sys_rst)
    byte_done && in_data && mb_ff |=> ptr_ff == $past(ptr_ff) + 1'b1)
    else $error("pointer did not advance");
  a_ptr_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    byte_done && in_data && !mb_ff |=> $stable(ptr_ff))
    else $error("pointer moved without multi-byte flag");
  a_frame_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    cs_hi |=> bit_cnt_ff == '0 && phase_ff == SSP_IDLE)
    else $error("frame state survived select rise");
  a_header_fields: assert property (@(posedge mclk) disable iff (sys_rst)
    byte_done && phase_ff == SSP_HDR
    |=> rw_ff == $past(byte_in[SSP_RW_POS]) && ptr_ff == $past(byte_in[5:0]))
    else $error("header fields not captured");
  a_wire_mode_set: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_en && fmt_hit |=> three_wire_ff == $past(byte_in[SSP_WIRE_POS]))
    else $error("wire-count bit not taken");
  c_write_frame: cover property (@(posedge mclk) disable iff (sys_rst) wr_en);
  c_burst_read: cover property (@(posedge mclk) disable iff (sys_rst)
    byte_done && in_data && rw_ff && mb_ff);
  c_three_wire_read: cover property (@(posedge mclk) disable iff (sys_rst) sdio_oe_ff);
  c_mode_switch: cover property (@(posedge mclk) disable iff (sys_rst) $rose(three_wire_ff));
endmodule

/* testbench/ssp_spi_master.sv */
// Behavioural SPI bus master that faces the serial port
`timescale 1ns/1ps
module ssp_spi_master
(
  input wire logic mclk,
  input wire logic miso,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  output logic mosi_oe
);
  // Lines idle driven: select high, clock high, data high
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b1;
    mosi_oe = 1'b1;
  end

  // Open a frame, leave room for the select synchroniser
  task automatic start();
    @(posedge mclk);
    cs_n <= 1'b0;
    mosi_oe <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  // Shift nb bits MSB first, mode 3, 800 ns per bit, well under 5 MHz
  // Device bit lands 3 mclk after the fall, so it is settled at the rise
  task automatic xbyte(input logic [7:0] tx, input logic rd, input int nb,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      @(posedge mclk);
      sclk <= 1'b0;
      mosi <= rd ? 1'b1 : tx[i];
      mosi_oe <= !rd;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (3) @(posedge mclk);
    end
  endtask

  // Close the frame and park all lines high
  task automatic stop();
    repeat (2) @(posedge mclk);
    cs_n <= 1'b1;
    mosi <= 1'b1;
    // Retake the shared pin only after the device has let it go
    repeat (4) @(posedge mclk);
    mosi_oe <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
endmodule

/* testbench/tb_sensor_serial_port_spi.sv */
// Self-checking bench for the sensor serial port SPI slave
`timescale 1ns/1ps
module tb_sensor_serial_port_spi
  import ssp_pkg::*;
;
  logic mclk, sys_rst, park;
  logic cs_n, sclk, mosi, mosi_oe, miso_w, sdio_w;
  logic sdo, sdo_oe, sdio_out, sdio_oe, twowire_sel, three_wire, reg_wr_stb;
  logic [SSP_ADDR_W-1:0] reg_wr_addr;
  logic [SSP_DATA_W-1:0] reg_wr_data;
  logic [7:0] txq[$], rxq[$];
  logic [13:0] wq[$];
  logic [7:0] r;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  // ****************************************
  // Clock, wire resolution, instances
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  assign sdio_w = sdio_oe ? sdio_out : (mosi_oe ? mosi : park);
  assign miso_w = three_wire ? sdio_w : (sdo_oe ? sdo : park);
  // Released lines float to the inverse of the last level
  always @(posedge mclk) park <= ~miso_w;
  ssp_spi_master m (.mclk(mclk), .miso(miso_w), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .mosi_oe(mosi_oe));
  ssp_spi_slave dut (.mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .sdi(mosi),
    .sdo(sdo), .sdo_oe(sdo_oe), .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .twowire_sel(twowire_sel), .three_wire(three_wire), .reg_wr_stb(reg_wr_stb),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
  // ****************************************
  // Monitors, compare and closing
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Collect register writes; flag a fight on the shared pin
  always @(posedge mclk)
  begin
    if (reg_wr_stb === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
    if (sdio_oe === 1'b1 && mosi_oe === 1'b1) chk(1, 0, "sdio contention");
    cyc++;
    if (cyc == 10000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic wchk(input logic [13:0] exp);
    chk(wq.size() > 0 ? wq.pop_front() : 16'hFFFF, exp, "write");
  endtask
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One frame: header, n data bytes, in-frame pin checks
  task automatic frame(input logic [7:0] hdr, input logic rd, input int n);
    m.start();
    chk(twowire_sel, 0, "twowire in frame");
    chk(sdo_oe, !three_wire, "sdo_oe in frame");
    m.xbyte(hdr, 1'b0, 8, r);
    chk(sdio_oe, 0, "sdio_oe header");
    for (int k = 0; k < n; k++)
    begin
      m.xbyte(rd ? 8'hFF : txq[k], rd, 8, r);
      if (rd) rxq.push_back(r);
      chk(sdio_oe, rd & three_wire, "sdio_oe data");
    end
    m.stop();
    chk({sdo_oe, sdio_oe, twowire_sel}, 3'b001, "release");
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    sys_rst <= 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({sdo, sdo_oe, sdio_oe, twowire_sel, three_wire, reg_wr_stb}, 6'h24, "reset");
    txq = '{8'hA5};
    frame(8'h05, 1'b0, 1);
    wchk({6'h05, 8'hA5});
    txq = '{8'h11, 8'h22, 8'h33};
    frame(8'h7F, 1'b0, 3);
    wchk({6'h3F, 8'h11});
    wchk({6'h00, 8'h22});
    wchk({6'h01, 8'h33});
    txq = '{8'h44, 8'h55};
    frame(8'h10, 1'b0, 2);
    wchk({6'h10, 8'h44});
    wchk({6'h10, 8'h55});
    m.start();
    m.xbyte(8'h20, 1'b0, 8, r);
    m.xbyte(8'hF0, 1'b0, 4, r);
    m.stop();
    chk(wq.size(), 0, "partial byte");
    frame(8'hFF, 1'b1, 3);
    chk(rxq.pop_front(), 8'h11, "read 3F");
    chk(rxq.pop_front(), 8'h22, "read 00");
    chk(rxq.pop_front(), 8'h33, "read 01");
    txq = '{8'h40};
    frame(8'h31, 1'b0, 1);
    wchk({6'h31, 8'h40});
    chk(three_wire, 1, "three wire set");
    frame(8'h85, 1'b1, 1);
    chk(rxq.pop_front(), 8'hA5, "3-wire read");
    txq = '{8'h00};
    frame(8'h31, 1'b0, 1);
    wchk({6'h31, 8'h00});
    chk(three_wire, 0, "four wire back");
    conclude();
  end
endmodule
